// >>> hdl/ubr_pkg.sv
// Package with register map, field positions, encodings and carriers of the serial data block.
package ubr_pkg;
    localparam logic [3:0] IDX_RXL   = 4'h0;
    localparam logic [3:0] IDX_RXH   = 4'h1;
    localparam logic [3:0] IDX_TXL   = 4'h2;
    localparam logic [3:0] IDX_TXH   = 4'h3;
    localparam logic [3:0] IDX_STAT  = 4'h4;
    localparam logic [3:0] IDX_CTLA  = 4'h5;
    localparam logic [3:0] IDX_CTLB  = 4'h6;
    localparam logic [3:0] IDX_CTLC  = 4'h7;
    localparam logic [3:0] IDX_BAUD  = 4'h8;
    localparam logic [3:0] IDX_DBG   = 4'hb;
    localparam logic [3:0] IDX_EVT   = 4'hc;
    localparam logic [3:0] IDX_TXPL  = 4'hd;
    localparam logic [3:0] IDX_RXPL  = 4'he;
    localparam int ST_RXC  = 7;
    localparam int ST_TXC  = 6;
    localparam int ST_DRE  = 5;
    localparam int ST_RXS  = 4;
    localparam int ST_ISF  = 3;
    localparam int ST_BDF  = 1;
    localparam int ST_WFB  = 0;
    localparam int RXH_OVF = 6;
    localparam int RXH_FE  = 2;
    localparam int RXH_PE  = 1;
    localparam logic [7:0] RST_STAT  = 8'h20;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_BAUD = 16'h0010;
    localparam logic [2:0] CS_5  = 3'h0;
    localparam logic [2:0] CS_9L = 3'h6;
    localparam logic [2:0] CS_9H = 3'h7;
    localparam logic [1:0] CM_SPI  = 2'h3;
    localparam logic [1:0] PM_EVEN = 2'h2;
    localparam logic [1:0] PM_ODD  = 2'h3;
    localparam logic [1:0] RXM_LIN = 2'h3;
    localparam logic [7:0] LIN_SYNC = 8'h55;
    typedef struct packed {
        logic [8:0] data;
        logic       framing_error_flag;
        logic       parity_error_flag;
    } ubr_frame_t;
    typedef enum logic [1:0] {LIN_BRK, LIN_SYN, LIN_PID, LIN_RSP} ubr_lin_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ubr_rx_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ubr_tx_t;
endpackage

// >>> hdl/ubr_top.sv
// Serial transceiver data registers with APB register access, receive buffer and transmitter.
module ubr_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]          status, ctla, ctlb, ctlc, dbg, evt, txpl, rxpl;
    logic [15:0]         baud;
    ubr_pkg::ubr_frame_t rx_buf [2];
    logic [1:0]          rx_count;
    ubr_pkg::ubr_frame_t rx_hold;
    logic                rx_wait, ovf, rd_had;
    logic [8:0]          tx_buf;
    logic                tx_full;
    logic                rx_s1, rx_s2, rx_prev;
    ubr_pkg::ubr_rx_t    rx_st;
    ubr_pkg::ubr_tx_t    tx_st;
    ubr_pkg::ubr_lin_t   lin_ph;
    logic [15:0]         rx_cnt, tx_cnt;
    logic [3:0]          rx_bit, tx_left;
    logic [8:0]          rx_sh;
    logic                rx_parity_error_flag;
    logic [12:0]         tx_sh;

    function automatic logic [3:0] nbits(input logic [2:0] cs);
        nbits = (cs >= ubr_pkg::CS_9L) ? 4'd9 : 4'd5 + {2'b00, cs[1:0]};
    endfunction

    function automatic logic par_of(input logic [8:0] d, input logic [3:0] n,
                                    input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < n) begin
                p = p ^ d[i];
            end
        end
        par_of = p;
    endfunction

    wire       setup   = psel && !penable;
    wire       xfer    = psel && penable && pready;
    wire [3:0] idx     = paddr[5:2];
    wire       nine_lf = ctlc[2:0] == ubr_pkg::CS_9L;
    wire       spi_h   = ctlc[7:6] == ubr_pkg::CM_SPI;
    wire       par_en  = ctlc[5];
    wire       lin     = ctlb[2:1] == ubr_pkg::RXM_LIN;
    wire [3:0] nb      = nbits(ctlc[2:0]);
    wire [15:0] bitlen = (baud == 16'h0000) ? 16'h0001 : baud;
    wire       rx_in   = ctla[3] ? txd : rx_s2;
    wire       mapped  = idx <= ubr_pkg::IDX_BAUD || (idx >= ubr_pkg::IDX_DBG &&
                         idx <= ubr_pkg::IDX_RXPL);
    wire       rd_rx   = xfer && !pwrite && (idx == ubr_pkg::IDX_RXL ||
                         idx == ubr_pkg::IDX_RXH);
    wire       rx_pop  = rd_rx && rd_had && (nine_lf ? idx == ubr_pkg::IDX_RXH
                         : idx == ubr_pkg::IDX_RXL);
    wire       tx_push = xfer && pwrite && (nine_lf ? idx == ubr_pkg::IDX_TXH
                         : idx == ubr_pkg::IDX_TXL);
    wire       wr      = xfer && pwrite;
    wire       rx_mid  = rx_cnt == 16'h0000;
    wire       rx_done = rx_st == ubr_pkg::RX_STOP && rx_mid;
    wire       start   = rx_st == ubr_pkg::RX_IDLE && ctlb[7] && rx_prev && !rx_in;
    wire       tx_load = tx_st == ubr_pkg::TX_IDLE && tx_full && ctlb[6];
    wire       tx_end  = tx_st == ubr_pkg::TX_SHIFT && tx_cnt == 16'h0001 && tx_left == 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Frame completion: LIN break and sync bytes steer the phase; the sync byte, and a break in the break or sync phase, are not buffered.
    ubr_pkg::ubr_frame_t done_f;
    logic                done_keep;
    always_comb begin
        done_f.data = rx_sh;
        done_f.framing_error_flag = !rx_in;
        done_f.parity_error_flag = par_en && rx_parity_error_flag;
        done_keep   = rx_done;
        if (lin) begin
            done_f.data[8] = lin_ph == ubr_pkg::LIN_RSP;
            done_f.parity_error_flag    = 1'b0;
            done_keep      = rx_done && (lin_ph == ubr_pkg::LIN_PID ||
                             lin_ph == ubr_pkg::LIN_RSP);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lin_ph <= ubr_pkg::LIN_BRK;
        end else if (rx_done && lin) begin
            if (rx_sh == 9'h000 && !rx_in) begin
                lin_ph <= ubr_pkg::LIN_SYN;
            end else if (lin_ph == ubr_pkg::LIN_SYN) begin
                lin_ph <= ubr_pkg::LIN_PID;
            end else if (lin_ph == ubr_pkg::LIN_PID) begin
                lin_ph <= ubr_pkg::LIN_RSP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry receive buffer plus one frame parked in rx_hold, apart from the shift register.
    // A frame that completes while one is already parked, with no pop in that cycle, is dropped, as overrun reports.
    wire push_new  = done_keep && !(rx_count == 2'd2 && !rx_pop);
    wire park_new  = done_keep && rx_count == 2'd2 && !rx_pop && !rx_wait;
    wire push_any  = push_new || (rx_wait && rx_pop);
    ubr_pkg::ubr_frame_t push_f;
    assign push_f = (rx_wait && rx_pop) ? rx_hold : done_f;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_count <= 2'd0;
            rx_buf   <= '{default: '0};
            rx_hold  <= '0;
            rx_wait  <= 1'b0;
        end else begin
            if (rx_pop) begin
                rx_buf[0] <= rx_buf[1];
            end
            if (push_any) begin
                rx_buf[(rx_count - {1'b0, rx_pop}) == 2'd0 ? 0 : 1] <= push_f;
            end
            rx_count <= rx_count + {1'b0, push_any} - {1'b0, rx_pop};
            if (park_new) begin
                rx_hold <= done_f;
                rx_wait <= 1'b1;
            end else if (rx_pop && rx_wait) begin
                rx_hold <= done_f;
                rx_wait <= done_keep;
            end
        end
    end

    // Setting wins over the read that clears.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf <= 1'b0;
        end else if (start && rx_count == 2'd2 && rx_wait) begin
            ovf <= 1'b1;
        end else if (rd_rx) begin
            ovf <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver: the start is rechecked at half a bit so glitches are dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1   <= 1'b1;
            rx_s2   <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_s1   <= rxd;
            rx_s2   <= rx_s1;
            rx_prev <= rx_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st   <= ubr_pkg::RX_IDLE;
            rx_cnt  <= 16'h0000;
            rx_bit  <= 4'h0;
            rx_sh   <= 9'h000;
            rx_parity_error_flag <= 1'b0;
        end else begin
            rx_cnt <= rx_mid ? bitlen - 16'h0001 : rx_cnt - 16'h0001;
            case (rx_st)
                ubr_pkg::RX_IDLE: begin
                    if (start) begin
                        rx_st  <= ubr_pkg::RX_START;
                        rx_cnt <= {1'b0, bitlen[15:1]};
                    end
                end
                ubr_pkg::RX_START: begin
                    if (rx_mid) begin
                        rx_st  <= rx_in ? ubr_pkg::RX_IDLE : ubr_pkg::RX_DATA;
                        rx_bit <= 4'h0;
                        rx_sh  <= 9'h000;
                    end
                end
                ubr_pkg::RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh[rx_bit] <= rx_in;
                        rx_bit        <= rx_bit + 4'h1;
                        if (rx_bit == nb - 4'h1) begin
                            rx_st <= par_en ? ubr_pkg::RX_PAR : ubr_pkg::RX_STOP;
                        end
                    end
                end
                ubr_pkg::RX_PAR: begin
                    if (rx_mid) begin
                        rx_parity_error_flag <= par_of(rx_sh, nb, ctlc[4]) != rx_in;
                        rx_st   <= ubr_pkg::RX_STOP;
                    end
                end
                ubr_pkg::RX_STOP: begin
                    if (rx_mid) begin
                        rx_st   <= ubr_pkg::RX_IDLE;
                        rx_parity_error_flag <= 1'b0;
                    end
                end
                default: rx_st <= ubr_pkg::RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer and shift register; bits beyond the frame stay at stop level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf  <= 9'h000;
            tx_full <= 1'b0;
        end else begin
            if (wr && idx == ubr_pkg::IDX_TXL) begin
                tx_buf[7:0] <= pwdata[7:0];
            end
            if (wr && idx == ubr_pkg::IDX_TXH) begin
                tx_buf[8] <= pwdata[0];
            end
            if (tx_push) begin
                tx_full <= 1'b1;
            end else if (tx_load) begin
                tx_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st   <= ubr_pkg::TX_IDLE;
            tx_sh   <= 13'h1fff;
            tx_cnt  <= 16'h0000;
            tx_left <= 4'h0;
            txd     <= 1'b1;
        end else begin
            case (tx_st)
                ubr_pkg::TX_IDLE: begin
                    txd <= 1'b1;
                    if (tx_load) begin
                        tx_st   <= ubr_pkg::TX_SHIFT;
                        tx_sh   <= ({13{1'b1}} << (nb + {3'h0, par_en} + 4'h1)) |
                                   ({12'h000, par_of(tx_buf, nb, ctlc[4]) & par_en}
                                    << (nb + 4'h1)) |
                                   ({4'h0, tx_buf & ~(9'h1ff << nb)} << 1);
                        tx_left <= nb + {3'h0, par_en} + {3'h0, ctlc[3]} + 4'h3;
                        tx_cnt  <= 16'h0001;
                    end
                end
                ubr_pkg::TX_SHIFT: begin
                    if (tx_cnt == 16'h0001) begin
                        txd     <= tx_sh[0];
                        tx_sh   <= {1'b1, tx_sh[12:1]};
                        tx_left <= tx_left - 4'h1;
                        tx_cnt  <= bitlen;
                        if (tx_left == 4'h1) begin
                            tx_st <= ubr_pkg::TX_IDLE;
                            txd   <= 1'b1;
                        end
                    end else begin
                        tx_cnt <= tx_cnt - 16'h0001;
                    end
                end
                default: tx_st <= ubr_pkg::TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers. Status bits 7 to 4 are the interrupt sources; control A masks them.
    wire       stat_wr     = wr && idx == ubr_pkg::IDX_STAT;
    wire [7:0] next_status = {rx_count != 2'd0,
        (status[ubr_pkg::ST_TXC] && !(stat_wr && pwdata[ubr_pkg::ST_TXC])) ||
        (tx_end && !tx_full), !tx_full,
        status[ubr_pkg::ST_RXS] && !(stat_wr && pwdata[ubr_pkg::ST_RXS]),
        (status[ubr_pkg::ST_ISF] && !(stat_wr && pwdata[ubr_pkg::ST_ISF])) ||
        (rx_done && lin && lin_ph == ubr_pkg::LIN_SYN && rx_sh[7:0] != ubr_pkg::LIN_SYNC),
        1'b0,
        (status[ubr_pkg::ST_BDF] && !(stat_wr && pwdata[ubr_pkg::ST_BDF]) &&
         !push_any) || (rx_done && lin && lin_ph == ubr_pkg::LIN_SYN),
        stat_wr ? pwdata[ubr_pkg::ST_WFB] : status[ubr_pkg::ST_WFB]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= ubr_pkg::RST_STAT;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status[7:4] & ctla[7:4]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctla <= ubr_pkg::RST_BYTE;
            ctlb <= ubr_pkg::RST_BYTE;
            ctlc <= ubr_pkg::RST_BYTE;
            dbg  <= ubr_pkg::RST_BYTE;
            evt  <= ubr_pkg::RST_BYTE;
            txpl <= ubr_pkg::RST_BYTE;
            rxpl <= ubr_pkg::RST_BYTE;
            baud <= ubr_pkg::RST_BAUD;
        end else if (wr) begin
            case (idx)
                ubr_pkg::IDX_CTLA: ctla <= pwdata[7:0];
                ubr_pkg::IDX_CTLB: ctlb <= pwdata[7:0] & 8'hdf;
                ubr_pkg::IDX_CTLC: ctlc <= pwdata[7:0];
                ubr_pkg::IDX_BAUD: baud <= pwdata[15:0];
                ubr_pkg::IDX_DBG:  dbg  <= {7'h00, pwdata[0]};
                ubr_pkg::IDX_EVT:  evt  <= {7'h00, pwdata[0]};
                ubr_pkg::IDX_TXPL: txpl <= pwdata[7:0];
                ubr_pkg::IDX_RXPL: rxpl <= {1'b0, pwdata[6:0]};
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle, so every transfer takes no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            rd_had  <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            rd_had  <= rx_count != 2'd0;
            prdata  <= 32'h0000_0000;
            if (setup && !pwrite) begin
                case (idx)
                    ubr_pkg::IDX_RXL:  prdata[7:0] <= rx_buf[0].data[7:0];
                    ubr_pkg::IDX_RXH:  prdata[7:0] <= {rx_count != 2'd0,
                        ovf && !spi_h, 3'b000, rx_buf[0].framing_error_flag && !spi_h,
                        rx_buf[0].parity_error_flag && !spi_h, rx_buf[0].data[8]};
                    ubr_pkg::IDX_STAT: prdata[7:0] <= status;
                    ubr_pkg::IDX_CTLA: prdata[7:0] <= ctla;
                    ubr_pkg::IDX_CTLB: prdata[7:0] <= ctlb;
                    ubr_pkg::IDX_CTLC: prdata[7:0] <= ctlc;
                    ubr_pkg::IDX_BAUD: prdata[15:0] <= baud;
                    ubr_pkg::IDX_DBG:  prdata[7:0] <= dbg;
                    ubr_pkg::IDX_EVT:  prdata[7:0] <= evt;
                    ubr_pkg::IDX_TXPL: prdata[7:0] <= txpl;
                    ubr_pkg::IDX_RXPL: prdata[7:0] <= rxpl;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_rx_head: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == ubr_pkg::IDX_RXL |=> prdata[7:0] == $past(rx_buf[0].data[7:0]))
        else $error("receive-low does not show the oldest frame");
    chk_buf_depth: assert property (@(posedge pclk) disable iff (!presetn)
        rx_count == 2'd2 && !rx_pop |=> rx_count == 2'd2)
        else $error("full receive buffer lost a frame");
    chk_pop_sel: assert property (@(posedge pclk) disable iff (!presetn)
        rx_pop |-> (nine_lf ? idx == ubr_pkg::IDX_RXH : idx == ubr_pkg::IDX_RXL))
        else $error("receive buffer advanced on the wrong byte");
    chk_rxc_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_count == 2'd1 && rx_pop && !push_any |=> rx_count == 2'd0 ##1 !status[ubr_pkg::ST_RXC])
        else $error("receive-complete flag stays after buffer empties");
    chk_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_rx && !start |=> !ovf)
        else $error("overrun not cleared by data read");
    chk_spi_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == ubr_pkg::IDX_RXH && spi_h |=> prdata[6:1] == 6'h00)
        else $error("error flags visible in synchronous host mode");
    chk_tx_push: assert property (@(posedge pclk) disable iff (!presetn)
        tx_push |=> tx_full ##1 !status[ubr_pkg::ST_DRE])
        else $error("transmit push did not fill the buffer");
    chk_tx_idle: assert property (@(posedge pclk) disable iff (!presetn)
        tx_st == ubr_pkg::TX_IDLE && $past(tx_st) == ubr_pkg::TX_IDLE |-> txd)
        else $error("serial output not idle high");
endmodule // ubr_top

// >>> test/ubr_line_model.sv
// Remote serial party on the line: frame sender onto the receive pin and frame sampler on txd.
module ubr_line_model #(
    parameter int BIT_CYC = 8
) (
    input  wire logic pclk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Corrupt parity or stop bit only when the caller asks for it, to provoke the error flags.
    task automatic send(input logic [8:0] d, input int nb, input logic par_en,
                        input logic par_flip, input logic stop);
        logic par;
        par = ^(d & ((9'h001 << nb) - 9'h001)) ^ par_flip;
        @(posedge pclk);
        rxd <= 1'b0;
        repeat (BIT_CYC) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            rxd <= d[i];
            repeat (BIT_CYC) @(posedge pclk);
        end
        if (par_en) begin
            rxd <= par;
            repeat (BIT_CYC) @(posedge pclk);
        end
        rxd <= stop;
        repeat (BIT_CYC) @(posedge pclk);
        rxd <= 1'b1;
        repeat (BIT_CYC) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Samples mid-bit; the stop bit is not looked at.
    task automatic get(input int nb, output logic [8:0] d);
        d = 9'h000;
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT_CYC) @(posedge pclk);
            d[i] = txd;
        end
    endtask
endmodule // ubr_line_model

// >>> test/tb.sv
// Self-checking testbench of the serial data registers over APB.
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq;
    logic [5:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [8:0]  g;
    logic [7:0]  r;
    logic        e;
    int          error_cnt, num_checks;
    logic [7:0]  dat [4] = '{8'ha5, 8'h3c, 8'h0f, 8'hf0};

    ubr_top ubr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    ubr_line_model #(.BIT_CYC(8)) ubr_line_model_inst (.pclk(pclk), .txd(txd), .rxd(rxd));

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // The request stands until pready is seen high at a rising edge; the answer is taken there.
    task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            conclude();
        end
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] x;
        logic       y;
        apb(1'b1, idx, d, x, y);
    endtask

    task automatic rchk(input logic [3:0] idx, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        logic [7:0] x;
        logic       y;
        apb(1'b0, idx, 8'h00, x, y);
        `CHK($sformatf("register %0h", idx), exp, x & m)
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        conclude();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 6'h00; pwdata = 32'h00000000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk(ubr_pkg::IDX_STAT, ubr_pkg::RST_STAT);
        rchk(ubr_pkg::IDX_RXL, 8'h00);
        rchk(ubr_pkg::IDX_RXH, 8'h00);
        apb(1'b0, 4'h9, 8'h00, r, e);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 8'h00, r)
        wr(ubr_pkg::IDX_BAUD, 8'h08);
        wr(ubr_pkg::IDX_CTLC, 8'h03);
        wr(ubr_pkg::IDX_CTLB, 8'hc0);
        // Two buffered, one parked, the fourth start bit overruns.
        for (int i = 0; i < 4; i++) ubr_line_model_inst.send({1'b0, dat[i]}, 8, 1'b0, 1'b0, 1'b1);
        rchk(ubr_pkg::IDX_RXH, 8'hc0);
        rchk(ubr_pkg::IDX_RXL, dat[0]);
        rchk(ubr_pkg::IDX_RXH, 8'h80);
        rchk(ubr_pkg::IDX_RXL, dat[1]);
        rchk(ubr_pkg::IDX_RXH, 8'h80);
        rchk(ubr_pkg::IDX_RXL, dat[2]);
        rchk(ubr_pkg::IDX_RXH, 8'h00, 8'h80);
        wr(ubr_pkg::IDX_CTLC, 8'h23);
        ubr_line_model_inst.send(9'h011, 8, 1'b1, 1'b0, 1'b0);
        ubr_line_model_inst.send(9'h022, 8, 1'b1, 1'b1, 1'b1);
        rchk(ubr_pkg::IDX_RXH, 8'h84);
        rchk(ubr_pkg::IDX_RXL, 8'h11);
        rchk(ubr_pkg::IDX_RXH, 8'h82);
        rchk(ubr_pkg::IDX_RXL, 8'h22);
        ubr_line_model_inst.send(9'h033, 8, 1'b1, 1'b1, 1'b0);
        wr(ubr_pkg::IDX_CTLC, 8'hc3);
        rchk(ubr_pkg::IDX_RXH, 8'h80);
        rchk(ubr_pkg::IDX_RXL, 8'h33);
        wr(ubr_pkg::IDX_CTLC, 8'h06);
        ubr_line_model_inst.send(9'h1c3, 9, 1'b0, 1'b0, 1'b1);
        rchk(ubr_pkg::IDX_RXL, 8'hc3);
        rchk(ubr_pkg::IDX_RXH, 8'h81);
        rchk(ubr_pkg::IDX_STAT, 8'h20);
        wr(ubr_pkg::IDX_CTLC, 8'h03);
        fork
            ubr_line_model_inst.get(8, g);
            wr(ubr_pkg::IDX_TXL, 8'h96);
        join
        `CHK("sent frame", 9'h096, g)
        wr(ubr_pkg::IDX_CTLC, 8'h06);
        fork
            ubr_line_model_inst.get(9, g);
            begin
                wr(ubr_pkg::IDX_TXL, 8'h3a);
                wr(ubr_pkg::IDX_TXH, 8'h01);
            end
        join
        `CHK("sent frame", 9'h13a, g)
        repeat (30) @(posedge pclk);
        rchk(ubr_pkg::IDX_STAT, 8'h60);
        `CHK("irq masked", 1'b0, irq)
        wr(ubr_pkg::IDX_CTLA, 8'h40);
        repeat (2) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        wr(ubr_pkg::IDX_STAT, 8'h40);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        rchk(ubr_pkg::IDX_STAT, 8'h20);
        wr(ubr_pkg::IDX_CTLC, 8'h03);
        wr(ubr_pkg::IDX_CTLB, 8'hc6);
        ubr_line_model_inst.send(9'h000, 8, 1'b0, 1'b0, 1'b0);
        ubr_line_model_inst.send({1'b0, ubr_pkg::LIN_SYNC}, 8, 1'b0, 1'b0, 1'b1);
        ubr_line_model_inst.send(9'h0a3, 8, 1'b0, 1'b0, 1'b1);
        ubr_line_model_inst.send(9'h077, 8, 1'b0, 1'b0, 1'b1);
        rchk(ubr_pkg::IDX_RXH, 8'h80, 8'h81);
        rchk(ubr_pkg::IDX_RXL, 8'ha3);
        rchk(ubr_pkg::IDX_RXH, 8'h81, 8'h81);
        rchk(ubr_pkg::IDX_RXL, 8'h77);
        // Odd parity from the line, then a loop-back frame with two stop bits.
        wr(ubr_pkg::IDX_CTLB, 8'hc0);
        wr(ubr_pkg::IDX_CTLC, 8'h33);
        ubr_line_model_inst.send(9'h05a, 8, 1'b1, 1'b1, 1'b1);
        rchk(ubr_pkg::IDX_RXH, 8'h80);
        rchk(ubr_pkg::IDX_RXL, 8'h5a);
        wr(ubr_pkg::IDX_CTLA, 8'h08);
        wr(ubr_pkg::IDX_CTLC, 8'h3b);
        wr(ubr_pkg::IDX_TXL, 8'hc5);
        repeat (150) @(posedge pclk);
        rchk(ubr_pkg::IDX_RXH, 8'h80);
        rchk(ubr_pkg::IDX_RXL, 8'hc5);
        conclude();
    end
endmodule // tb
